//--- rtl/ssl_loader.v
`timescale 1ns/1ps
`include "ssl_defines.vh"
// Functional notes
// RQ1 - Primary pump current from low three bits, secondary from high three bits.
// RQ2 - Host picks prescaler ratio keeping prescaler output at most 300 MHz.
// RQ3 - Detector sense bit selects phase detector polarity.
// RQ4 - Pump three-state bit high puts pump output in high impedance.
// RQ5 - Select bits 11 mark an initialization word with function word fields.
// RQ6 - Initialization word loads the function settings.
// RQ7 - Initialization word issues reset pulse: counters load state, pump three-state.
// RQ8 - Enable high, powerdown a set, b clear: pulse triggers synchronous power-down.
// RQ9 - Reset pulse leaves prescaler reference and oscillator buffer untouched.
// RQ10 - First divider word after initialization re-fires reset pulse, later ones not.
// RQ11 - Two low bits select latch: 00 ref, 01 divider, 10 function, 11 init.
// RQ12 - Init sequence: init, function, reference, divider, with hold bit cleared.
// RQ13 - Enable low powers down at once; raising it resumes aligned counting.
// RQ14 - Latch contents survive chip enable cycling.
// RQ15 - Hold sequence: function with hold set, ref, divider, function hold cleared.
// RQ16 - Hold bit keeps counters at load point, pump three-state, no power-down.
// RQ17 - Shift one bit per rising serial clock; strobe rise transfers word.
// RQ18 - Host serial clock at most 20 MHz.
// RQ19 - Host sends three bytes with strobe low, then raises strobe.
// RQ20 - Host makes four writes after power-up before output is active.
// RQ21 - Hold bit high keeps reference and divider counters in reset.
// RQ22 - Enable low disables device regardless of powerdown bits; input still latches.
// RQ23 - Words shift most significant bit first; select bits arrive last.
module ssl_loader #(
   parameter RST_PULSE_CYC = `SSL_RST_PULSE_CYC
) (
   // Clock and reset.
   input wire I_SYS_CLK,
   input wire I_RST,
   // Serial link pins.
   input wire I_SER_CLK,
   input wire I_SER_DATA,
   input wire I_LATCH_STROBE_PIN,
   input wire I_CHIP_ENABLE,
   // Latch contents.
   output reg [21:0] O_REF_WORD,
   output reg [21:0] O_DIV_WORD,
   output reg [21:0] O_FUNC_WORD,
   // Decoded function fields.
   output reg [2:0] O_PUMP_CURRENT_A,
   output reg [2:0] O_PUMP_CURRENT_B,
   output reg [1:0] O_PRESCALER_SEL,
   output reg O_DETECTOR_SENSE,
   output reg [2:0] O_MONITOR_SEL,
   // Control results.
   output reg O_PUMP_HIGH_Z,
   output reg O_COUNTER_RESET,
   output reg O_RESET_PULSE,
   output reg O_POWERED_DOWN,
   output reg O_SYNC_PD_REQ,
   output reg O_PROGRAMMED
);
   reg [2:0] sclk_s_q;
   reg [1:0] sdat_s_q;
   reg [2:0] le_s_q;
   reg [1:0] ce_s_q;
   reg [`SSL_WORD_W-1:0] shift_q;
   reg rearm_q;
   reg [7:0] pulse_cnt_q;
   reg sync_pd_q;
   reg [3:0] seen_q;
   wire sclk_rise;
   wire le_rise;
   wire ce_hi;
   wire [1:0] sel;
   wire fire;
   wire [21:0] func_nxt;
   wire init_load;
   wire div_load;
   wire pulse_on;
   wire sync_pd_set;
   wire sync_pd_clr;
   wire hold_on;
   wire tri_on;

   // Pulse length as loaded into the 8-bit down-counter.
   localparam [7:0] PULSE_LOAD = RST_PULSE_CYC[7:0];

   // True when the word held in the input register targets the given latch.
   function sel_is;
      input [1:0] word_sel;
      input [1:0] target;
      begin
         sel_is = (word_sel == target);
      end
   endfunction

   // True while a down-counter still has cycles left to run.
   function cnt_busy;
      input [7:0] cnt;
      begin
         cnt_busy = (cnt != 8'h00);
      end
   endfunction

   assign sclk_rise = sclk_s_q[1] & ~sclk_s_q[2];
   assign le_rise = le_s_q[1] & ~le_s_q[2];
   assign ce_hi = ce_s_q[1];
   assign sel = shift_q[1:0];
   assign init_load = le_rise & sel_is(sel, `SSL_SEL_INIT); // RQ5
   assign div_load = le_rise & sel_is(sel, `SSL_SEL_DIV);
   // An initialization word fires the pulse; so does the first divider word after it.
   assign fire = init_load | (div_load & rearm_q); // RQ7 RQ10
   assign func_nxt = shift_q[`SSL_WORD_W-1:2];
   // The pulse stands while its counter has cycles left.
   assign pulse_on = cnt_busy(pulse_cnt_q);
   // Synchronous power-down only when enabled, first bit set and second bit clear.
   assign sync_pd_set = init_load & ce_hi & func_nxt[`SSL_F_PD_A-2] & ~func_nxt[`SSL_F_PD_B-2]; // RQ8
   // Enable low overrides the programmed power-down mode.
   assign sync_pd_clr = ~ce_hi | ~O_FUNC_WORD[`SSL_F_PD_A-2]; // RQ22
   assign hold_on = O_FUNC_WORD[`SSL_F_HOLD-2]; // RQ16 RQ21
   assign tri_on = O_FUNC_WORD[`SSL_F_TRI-2]; // RQ4

   // Input synchronisers; the logic reads only the second stage and later.
   always @(posedge I_SYS_CLK) begin
      sclk_s_q <= {sclk_s_q[1:0], I_SER_CLK};
   end

   always @(posedge I_SYS_CLK) begin
      sdat_s_q <= {sdat_s_q[0], I_SER_DATA};
   end

   always @(posedge I_SYS_CLK) begin
      le_s_q <= {le_s_q[1:0], I_LATCH_STROBE_PIN};
   end

   always @(posedge I_SYS_CLK) begin
      ce_s_q <= {ce_s_q[0], I_CHIP_ENABLE};
   end

   // The input register and latches run whatever chip enable does.
   always @(posedge I_SYS_CLK) begin
      if (I_RST) begin
         shift_q <= 24'h00_0000;
         O_REF_WORD <= 22'h00_0000;
         O_DIV_WORD <= 22'h00_0000;
         O_FUNC_WORD <= `SSL_FUNC_RST;
         rearm_q <= 1'b0;
         seen_q <= 4'h0;
         O_PROGRAMMED <= 1'b0;
      end else begin
         if (sclk_rise) begin
            shift_q <= {shift_q[`SSL_WORD_W-2:0], sdat_s_q[1]}; // RQ17 RQ23
         end
         if (le_rise) begin // RQ17 RQ22 RQ14
            seen_q[sel] <= 1'b1;
            case (sel) // RQ11
               `SSL_SEL_REF: begin
                  O_REF_WORD <= func_nxt;
               end
               `SSL_SEL_DIV: begin
                  O_DIV_WORD <= func_nxt;
                  rearm_q <= 1'b0; // RQ10
               end
               `SSL_SEL_FUNC: begin
                  O_FUNC_WORD <= func_nxt;
               end
               default: begin
                  O_FUNC_WORD <= func_nxt; // RQ5 RQ6
                  rearm_q <= 1'b1; // RQ10
               end
            endcase
         end
         O_PROGRAMMED <= &seen_q;
      end
   end

   // Reset pulse lasts a fixed number of cycles; prescaler reference is not touched here.
   always @(posedge I_SYS_CLK) begin
      if (I_RST) begin
         pulse_cnt_q <= 8'h00;
         sync_pd_q <= 1'b0;
      end else begin
         if (fire) begin
            pulse_cnt_q <= PULSE_LOAD; // RQ7 RQ9
         end else if (pulse_on) begin
            pulse_cnt_q <= pulse_cnt_q - 8'h01;
         end
         // Sync power-down armed by an initialization word stays until the first power-down bit clears or enable drops.
         // A set and a clear in one cycle leave the request set.
         if (sync_pd_set) begin
            sync_pd_q <= 1'b1; // RQ8
         end else if (sync_pd_clr) begin
            sync_pd_q <= 1'b0;
         end
      end
   end

   // Decoded function fields follow the function latch one cycle later.
   always @(posedge I_SYS_CLK) begin
      if (I_RST) begin
         O_PUMP_CURRENT_A <= 3'h0;
         O_PUMP_CURRENT_B <= 3'h0;
         O_PRESCALER_SEL <= 2'h0;
         O_DETECTOR_SENSE <= 1'b0;
         O_MONITOR_SEL <= 3'h0;
      end else begin
         O_PUMP_CURRENT_A <= O_FUNC_WORD[`SSL_F_CUR_A_HI-2:`SSL_F_CUR_A_LO-2]; // RQ1
         O_PUMP_CURRENT_B <= O_FUNC_WORD[`SSL_F_CUR_B_HI-2:`SSL_F_CUR_B_LO-2]; // RQ1
         O_PRESCALER_SEL <= O_FUNC_WORD[`SSL_F_PRE_HI-2:`SSL_F_PRE_LO-2];
         O_DETECTOR_SENSE <= O_FUNC_WORD[`SSL_F_SENSE-2]; // RQ3
         O_MONITOR_SEL <= O_FUNC_WORD[`SSL_F_MON_HI-2:`SSL_F_MON_LO-2];
      end
   end

   // Counters and pump are forced to their safe state in reset, then follow hold, pulse and enable; the pump also follows three-state.
   always @(posedge I_SYS_CLK) begin
      if (I_RST) begin
         O_PUMP_HIGH_Z <= 1'b1;
         O_COUNTER_RESET <= 1'b1;
         O_RESET_PULSE <= 1'b0;
         O_POWERED_DOWN <= 1'b1;
         O_SYNC_PD_REQ <= 1'b0;
      end else begin
         O_RESET_PULSE <= pulse_on; // RQ7
         O_COUNTER_RESET <= hold_on | pulse_on | ~ce_hi; // RQ16 RQ21 RQ13
         O_PUMP_HIGH_Z <= tri_on | hold_on | pulse_on | ~ce_hi; // RQ4 RQ16 RQ7
         O_POWERED_DOWN <= ~ce_hi; // RQ22 RQ13
         O_SYNC_PD_REQ <= sync_pd_q; // RQ8
      end
   end
endmodule // ssl_loader

//--- rtl/ssl_defines.vh
`ifndef SSL_DEFINES_VH
`define SSL_DEFINES_VH
`define SSL_WORD_W 24
`define SSL_SEL_REF 2'h0
`define SSL_SEL_DIV 2'h1
`define SSL_SEL_FUNC 2'h2
`define SSL_SEL_INIT 2'h3
`define SSL_F_HOLD 2
`define SSL_F_PD_A 3
`define SSL_F_MON_LO 4
`define SSL_F_MON_HI 6
`define SSL_F_SENSE 7
`define SSL_F_TRI 8
`define SSL_F_FL_EN 9
`define SSL_F_FL_MODE 10
`define SSL_F_TMR_LO 11
`define SSL_F_TMR_HI 14
`define SSL_F_CUR_A_LO 15
`define SSL_F_CUR_A_HI 17
`define SSL_F_CUR_B_LO 18
`define SSL_F_CUR_B_HI 20
`define SSL_F_PD_B 21
`define SSL_F_PRE_LO 22
`define SSL_F_PRE_HI 23
`define SSL_FUNC_RST 22'h00_0000
`define SSL_RST_PULSE_CYC 4
`endif

//--- verification/ssl_loader_props.sv
`timescale 1ns/1ps
module ssl_loader_props #(
   parameter RST_PULSE_CYC = 4
) (
   // Watched ports.
   input wire I_SYS_CLK,
   input wire I_RST,
   input wire [21:0] O_FUNC_WORD,
   input wire [2:0] O_PUMP_CURRENT_A,
   input wire [2:0] O_PUMP_CURRENT_B,
   input wire [1:0] O_PRESCALER_SEL,
   input wire O_DETECTOR_SENSE,
   input wire O_PUMP_HIGH_Z,
   input wire O_COUNTER_RESET,
   input wire O_RESET_PULSE,
   input wire O_POWERED_DOWN
);
   reg [7:0] pulse_cnt_q;
   default clocking @(posedge I_SYS_CLK); endclocking
   default disable iff (I_RST);
   always @(posedge I_SYS_CLK) pulse_cnt_q <= (I_RST || !O_RESET_PULSE) ? 8'h00 : pulse_cnt_q + 8'h01;
   cur_a_a: assert property ($stable(O_FUNC_WORD) |-> O_PUMP_CURRENT_A == O_FUNC_WORD[15:13])
      else $error("current a");
   cur_b_a: assert property ($stable(O_FUNC_WORD) |-> O_PUMP_CURRENT_B == O_FUNC_WORD[18:16])
      else $error("current b");
   pre_sel_a: assert property ($stable(O_FUNC_WORD) |-> O_PRESCALER_SEL == O_FUNC_WORD[21:20])
      else $error("prescaler");
   sense_a: assert property ($stable(O_FUNC_WORD) |-> O_DETECTOR_SENSE == O_FUNC_WORD[5])
      else $error("sense");
   tri_pump_a: assert property (O_FUNC_WORD[6] && $stable(O_FUNC_WORD) |-> ##[0:1] O_PUMP_HIGH_Z)
      else $error("three-state");
   hold_a: assert property (O_FUNC_WORD[0] && $stable(O_FUNC_WORD) |-> ##[0:1] (O_COUNTER_RESET && O_PUMP_HIGH_Z))
      else $error("hold");
   pulse_len_a: assert property ($fell(O_RESET_PULSE) |-> pulse_cnt_q == RST_PULSE_CYC)
      else $error("pulse length");
   pulse_eff_a: assert property (O_RESET_PULSE |-> ##[0:1] (O_COUNTER_RESET && O_PUMP_HIGH_Z))
      else $error("pulse effect");
   ce_low_a: assert property ($rose(O_POWERED_DOWN) |-> ##[0:2] (O_PUMP_HIGH_Z && O_COUNTER_RESET))
      else $error("enable low");
   cover property ($rose(O_RESET_PULSE));
   cover property (O_FUNC_WORD[0] && O_COUNTER_RESET);
   cover property ($rose(O_POWERED_DOWN));
endmodule // ssl_loader_props

//--- verification/ssl_host_model.sv
`timescale 1ns/1ps
module ssl_host_model (
   // Serial link, host side.
   input wire i_clk,
   output logic o_sclk,
   output logic o_sdata,
   output logic o_strobe
);
   initial {o_sclk, o_sdata, o_strobe} = 3'h1;
   task send(input logic [23:0] w);
      integer i;
      begin
         @(posedge i_clk) #1 o_strobe = 1'b0;
         for (i = 23; i >= 0; i = i - 1) begin
            o_sdata = w[i];
            repeat (4) @(posedge i_clk);
            #1 o_sclk = 1'b1;
            repeat (4) @(posedge i_clk);
            #1 o_sclk = 1'b0;
         end
         // A released data line shows the inverse of its last bit.
         o_sdata = ~w[0];
         repeat (4) @(posedge i_clk);
         #1 o_strobe = 1'b1;
      end
   endtask
endmodule // ssl_host_model

//--- verification/tb.sv
`timescale 1ns/1ps
module tb;
   logic I_SYS_CLK = 1'b0;
   logic I_RST = 1'b1;
   logic I_CHIP_ENABLE = 1'b1;
   wire I_SER_CLK, I_SER_DATA, I_LATCH_STROBE_PIN, O_DETECTOR_SENSE, O_PUMP_HIGH_Z, O_COUNTER_RESET;
   wire O_RESET_PULSE, O_POWERED_DOWN, O_SYNC_PD_REQ, O_PROGRAMMED;
   wire [21:0] O_REF_WORD, O_DIV_WORD, O_FUNC_WORD;
   wire [2:0] O_PUMP_CURRENT_A, O_PUMP_CURRENT_B, O_MONITOR_SEL;
   wire [1:0] O_PRESCALER_SEL;
   integer failures = 0;
   integer total_checks = 0;
   integer cycles = 0;
   ssl_loader dut_u (
      .I_SYS_CLK(I_SYS_CLK),
      .I_RST(I_RST),
      .I_SER_CLK(I_SER_CLK),
      .I_SER_DATA(I_SER_DATA),
      .I_LATCH_STROBE_PIN(I_LATCH_STROBE_PIN),
      .I_CHIP_ENABLE(I_CHIP_ENABLE),
      .O_REF_WORD(O_REF_WORD),
      .O_DIV_WORD(O_DIV_WORD),
      .O_FUNC_WORD(O_FUNC_WORD),
      .O_PUMP_CURRENT_A(O_PUMP_CURRENT_A),
      .O_PUMP_CURRENT_B(O_PUMP_CURRENT_B),
      .O_PRESCALER_SEL(O_PRESCALER_SEL),
      .O_DETECTOR_SENSE(O_DETECTOR_SENSE),
      .O_MONITOR_SEL(O_MONITOR_SEL),
      .O_PUMP_HIGH_Z(O_PUMP_HIGH_Z),
      .O_COUNTER_RESET(O_COUNTER_RESET),
      .O_RESET_PULSE(O_RESET_PULSE),
      .O_POWERED_DOWN(O_POWERED_DOWN),
      .O_SYNC_PD_REQ(O_SYNC_PD_REQ),
      .O_PROGRAMMED(O_PROGRAMMED)
   );
   ssl_host_model host_u (.i_clk(I_SYS_CLK), .o_sclk(I_SER_CLK), .o_sdata(I_SER_DATA), .o_strobe(I_LATCH_STROBE_PIN));
   always #25 I_SYS_CLK = ~I_SYS_CLK;
   task test_done;
      begin
         $display("Checks %0d failures %0d", total_checks, failures);
         if (failures == 0 && total_checks > 0) $display("Run complete: PASS");
         else $display("Run complete: FAIL");
         $finish;
      end
   endtask
   task chk(input string n, input logic [23:0] e, input logic [23:0] g);
      begin
         total_checks = total_checks + 1;
         if (g !== e) begin
            failures = failures + 1;
            $display("Error %s expected %h seen %h", n, e, g);
         end
      end
   endtask
   // Writes one word, then watches a dozen cycles for the reset pulse.
   task wr(input logic [23:0] w, input logic p);
      logic s;
      begin
         host_u.send(w);
         s = 1'b0;
         repeat (12) @(posedge I_SYS_CLK) #1 s = s | O_RESET_PULSE;
         chk("latch", w[23:2], w[1:0] == 2'h0 ? O_REF_WORD : w[1:0] == 2'h1 ? O_DIV_WORD : O_FUNC_WORD);
         chk("pulse", p, s);
         $display("Test write %h done", w);
      end
   endtask
   always @(posedge I_SYS_CLK) begin
      cycles = cycles + 1;
      if (cycles == 6000) begin
         $display("Error timeout expected %0d seen %0d", 6000, cycles);
         failures = failures + 1;
         test_done;
      end
   end
   initial begin
      repeat (6) @(posedge I_SYS_CLK);
      #1 I_RST = 1'b0;
      wr(24'h95_8083, 1'b1);
      chk("fields", {15'h0, 3'h5, 3'h3, 2'h2, 1'h1}, {O_PUMP_CURRENT_B, O_PUMP_CURRENT_A, O_PRESCALER_SEL, O_DETECTOR_SENSE});
      wr(24'h00_1231, 1'b1);
      wr(24'h00_4561, 1'b0);
      wr(24'h12_3454, 1'b0);
      wr(24'h00_0106, 1'b0);
      chk("hold", 2'h3, {O_COUNTER_RESET, O_PUMP_HIGH_Z});
      wr(24'h00_00a2, 1'b0);
      chk("run", 2'h0, {O_COUNTER_RESET, O_PUMP_HIGH_Z});
      chk("mon", 3'h2, O_MONITOR_SEL);
      chk("prog", 1'b1, O_PROGRAMMED);
      @(posedge I_SYS_CLK) #1 I_CHIP_ENABLE = 1'b0;
      wr(24'h65_4320, 1'b0);
      chk("down", 3'h7, {O_POWERED_DOWN, O_PUMP_HIGH_Z, O_COUNTER_RESET});
      @(posedge I_SYS_CLK) #1 I_CHIP_ENABLE = 1'b1;
      repeat (6) @(posedge I_SYS_CLK);
      #1;
      chk("kept", 24'h28, O_FUNC_WORD);
      chk("up", 3'h0, {O_POWERED_DOWN, O_PUMP_HIGH_Z, O_COUNTER_RESET});
      wr(24'h00_000b, 1'b1);
      chk("syncpd", 1'b1, O_SYNC_PD_REQ);
      wr(24'h00_0082, 1'b0);
      chk("syncclr", 1'b0, O_SYNC_PD_REQ);
      wr(24'h00_0100, 1'b0);
      wr(24'h00_0201, 1'b1);
      test_done;
   end
endmodule // tb
bind ssl_loader ssl_loader_props #(.RST_PULSE_CYC(RST_PULSE_CYC)) props_u (
   .I_SYS_CLK(I_SYS_CLK),
   .I_RST(I_RST),
   .O_FUNC_WORD(O_FUNC_WORD),
   .O_PUMP_CURRENT_A(O_PUMP_CURRENT_A),
   .O_PUMP_CURRENT_B(O_PUMP_CURRENT_B),
   .O_PRESCALER_SEL(O_PRESCALER_SEL),
   .O_DETECTOR_SENSE(O_DETECTOR_SENSE),
   .O_PUMP_HIGH_Z(O_PUMP_HIGH_Z),
   .O_COUNTER_RESET(O_COUNTER_RESET),
   .O_RESET_PULSE(O_RESET_PULSE),
   .O_POWERED_DOWN(O_POWERED_DOWN)
);
